/* File: clock_domain_gating.sv */
// Clock domain generation and per-module clock gating under a global sleep controller.
`timescale 1ns/1ps
// Contract
// - All clocks derived from one reference.
// - Domains keep 1:1, 1:3, 1:6 ratio.
// - Ratio field holds divide-down minus one.
// - Reference domain runs at reference rate.
// - Each peripheral sits in its fixed domain.
// - One always-on power domain only.
// - Power saved only by clock gating.
// - Global controller holds registers and per-module machines.
// - Local controller drives clock enable and reset.
// - Controllers indexed by fixed module number.
module clock_domain_gating (
  input wire logic clock, // Reference-derived system clock, 25 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic [clock_gating_pkg::RATIO_WIDTH-1:0] ratio_one, // First divider code.
  input wire logic [clock_gating_pkg::RATIO_WIDTH-1:0] ratio_two, // Second divider code.
  input wire logic [clock_gating_pkg::RATIO_WIDTH-1:0] ratio_three, // Third divider code.
  input wire logic ratio_load, // Pulse: take the three ratio codes.
  input wire logic [clock_gating_pkg::MODULE_COUNT-1:0] enable_req, // Per-module run request.
  input wire logic [clock_gating_pkg::MODULE_COUNT-1:0] reset_req, // Per-module reset request.
  input wire logic power_off_req, // Domain switch-off request, never honoured.
  output logic full_rate_tick, // Full-rate domain enable.
  output logic third_rate_tick, // Third-rate domain enable.
  output logic sixth_rate_tick, // Sixth-rate domain enable.
  output logic reference_rate_tick, // Reference-rate domain enable.
  output logic [clock_gating_pkg::MODULE_COUNT-1:0] module_clock_enable, // Gated enables.
  output logic [clock_gating_pkg::MODULE_COUNT-1:0] module_reset_n, // Module resets.
  output logic [clock_gating_pkg::MODULE_COUNT-1:0] module_running, // Running status.
  output logic ratio_error, // Last load held an illegal ratio set.
  output logic power_domain_on // Always-on domain status.
);
  import clock_gating_pkg::*;

  logic [4:0] ratio_one_q; // Active first divider code.
  logic [4:0] ratio_one_d; // Next first divider code.
  logic [4:0] ratio_two_q; // Active second divider code.
  logic [4:0] ratio_two_d; // Next second divider code.
  logic [4:0] ratio_three_q; // Active third divider code.
  logic [4:0] ratio_three_d; // Next third divider code.
  logic ratio_error_q; // Registered ratio error.
  logic ratio_error_d; // Next ratio error.
  logic [4:0] count_one_q; // First divider counter.
  logic [4:0] count_one_d; // Next first divider counter.
  logic [4:0] count_two_q; // Second divider counter.
  logic [4:0] count_two_d; // Next second divider counter.
  logic [4:0] count_three_q; // Third divider counter.
  logic [4:0] count_three_d; // Next third divider counter.
  logic tick_full_q; // Registered full-rate tick.
  logic tick_full_d; // Next full-rate tick.
  logic tick_third_q; // Registered third-rate tick.
  logic tick_third_d; // Next third-rate tick.
  logic tick_sixth_q; // Registered sixth-rate tick.
  logic tick_sixth_d; // Next sixth-rate tick.
  logic [4:0] sel_two; // Second code now active.
  logic [4:0] sel_three; // Third code now active.
  logic [MODULE_COUNT-1:0] lsc_enable; // Local controller enables.
  logic [MODULE_COUNT-1:0] lsc_reset_n; // Local controller resets.
  logic [MODULE_COUNT-1:0] lsc_running; // Local controller states.
  logic [MODULE_COUNT-1:0] domain_ticks; // Tick routed to each module.
  logic [MODULE_COUNT-1:0] enable_q; // Registered outputs of enables.
  logic [MODULE_COUNT-1:0] reset_n_q; // Registered outputs of resets.
  logic [MODULE_COUNT-1:0] running_q; // Registered outputs of status.

  // True when the three codes form one of the allowed divider sets.
  function automatic logic ratio_set_legal(input logic [4:0] a, input logic [4:0] b,
                                           input logic [4:0] c);
    logic ok;
    ok = 1'b0;
    if (a == RATIO_DIV1 && b == RATIO_DIV3 && c == RATIO_DIV6) begin
      ok = 1'b1;
    end else if (a == RATIO_DIV2 && b == RATIO_DIV6 && c == RATIO_DIV12) begin
      ok = 1'b1;
    end else if (a == RATIO_DIV3 && b == RATIO_DIV9 && c == RATIO_DIV18) begin
      ok = 1'b1;
    end
    return ok;
  endfunction

  // Advances a divider counter that wraps after ratio plus one cycles.
  function automatic logic [4:0] count_next(input logic [4:0] cnt, input logic [4:0] ratio);
    logic [4:0] n;
    n = (cnt >= ratio) ? 5'h00 : 5'(cnt + 5'h01);
    return n;
  endfunction

  // Ratio loading: an illegal set is refused so the domains never lose their 1:3:6 relation.
  always_comb begin
    ratio_one_d = ratio_one_q;
    ratio_two_d = ratio_two_q;
    ratio_three_d = ratio_three_q;
    ratio_error_d = ratio_error_q;
    if (ratio_load) begin
      if (ratio_set_legal(ratio_one, ratio_two, ratio_three)) begin
        ratio_one_d = ratio_one;
        ratio_two_d = ratio_two;
        ratio_three_d = ratio_three;
        ratio_error_d = 1'b0;
      end else begin
        ratio_error_d = 1'b1;
      end
    end
  end

  // Registers the ratio codes and error flag.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ratio_one_q <= RESET_RATIO_ONE;
      ratio_two_q <= RESET_RATIO_TWO;
      ratio_three_q <= RESET_RATIO_THREE;
      ratio_error_q <= 1'b0;
    end else begin
      ratio_one_q <= ratio_one_d;
      ratio_two_q <= ratio_two_d;
      ratio_three_q <= ratio_three_d;
      ratio_error_q <= ratio_error_d;
    end
  end

  // Divider counters, all running off the one clock; the slower counters restart
  // together with the first so every divided tick falls on a full-rate tick.
  always_comb begin
    sel_two = ratio_two_q;
    sel_three = ratio_three_q;
    count_one_d = count_next(count_one_q, ratio_one_q);
    count_two_d = count_next(count_two_q, sel_two);
    count_three_d = count_next(count_three_q, sel_three);
    if (ratio_load) begin
      count_one_d = 5'h00; // Realign all counters on every ratio load, even a refused one.
      count_two_d = 5'h00;
      count_three_d = 5'h00;
    end
    tick_full_d = (count_one_d == 5'h00);
    tick_third_d = (count_two_d == 5'h00);
    tick_sixth_d = (count_three_d == 5'h00);
  end

  // Registers the counters and ticks.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_one_q <= 5'h00;
      count_two_q <= 5'h00;
      count_three_q <= 5'h00;
      tick_full_q <= 1'b0;
      tick_third_q <= 1'b0;
      tick_sixth_q <= 1'b0;
    end else begin
      count_one_q <= count_one_d;
      count_two_q <= count_two_d;
      count_three_q <= count_three_d;
      tick_full_q <= tick_full_d;
      tick_third_q <= tick_third_d;
      tick_sixth_q <= tick_sixth_d;
    end
  end

  // Routes each module slot to the tick of its fixed domain.
  always_comb begin
    for (int i = 0; i < MODULE_COUNT; i++) begin
      unique case (domain_of(6'(i)))
        DOMAIN_FULL: domain_ticks[i] = tick_full_q;
        DOMAIN_THIRD: domain_ticks[i] = tick_third_q;
        DOMAIN_SIXTH: domain_ticks[i] = tick_sixth_q;
        DOMAIN_REFERENCE: domain_ticks[i] = 1'b1;
      endcase
    end
  end

  // One state machine per slot, placed at its fixed module number.
  for (genvar g = 0; g < MODULE_COUNT; g++) begin : g_lsc
    local_sleep_controller u_lsc (
      .clock(clock),
      .rst_n(rst_n),
      .populated(POPULATED_MASK[g]),
      .enable_req(enable_req[g] & RESET_ENABLE_MASK[g]),
      .reset_req(reset_req[g]),
      .domain_tick(domain_ticks[g]),
      .clock_enable(lsc_enable[g]),
      .module_reset_n(lsc_reset_n[g]),
      .running(lsc_running[g])
    );
  end

  // Output registers so every top output comes from a flip-flop.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= '0;
      reset_n_q <= '0;
      running_q <= '0;
    end else begin
      enable_q <= lsc_enable;
      reset_n_q <= lsc_reset_n;
      running_q <= lsc_running;
    end
  end

  // The single domain is always on; a switch-off request has no effect.
  logic power_on_q; // Power domain status register.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      power_on_q <= 1'b1;
    end else begin
      power_on_q <= 1'b1 | power_off_req;
    end
  end

  // Reference domain tick register: the reference rate equals the system clock.
  logic tick_ref_q; // Reference-rate tick.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_ref_q <= 1'b0;
    end else begin
      tick_ref_q <= 1'b1;
    end
  end

  assign full_rate_tick = tick_full_q;
  assign third_rate_tick = tick_third_q;
  assign sixth_rate_tick = tick_sixth_q;
  assign reference_rate_tick = tick_ref_q;
  assign module_clock_enable = enable_q;
  assign module_reset_n = reset_n_q;
  assign module_running = running_q;
  assign ratio_error = ratio_error_q;
  assign power_domain_on = power_on_q;

endmodule

/* File: clock_gating_pkg.sv */
// Package of constants for the clock distribution and module clock gating block.
package clock_gating_pkg;

  // Number of local sleep controller slots, indices 0 to 40.
  localparam int unsigned MODULE_COUNT = 41;
  // Width of a module index.
  localparam int unsigned MODULE_INDEX_WIDTH = 6;
  // Width of a divider ratio field.
  localparam int unsigned RATIO_WIDTH = 5;

  // Divider ratio codes, each a divide-down of N written as N minus one.
  localparam logic [4:0] RATIO_DIV1 = 5'h00;
  localparam logic [4:0] RATIO_DIV2 = 5'h01;
  localparam logic [4:0] RATIO_DIV3 = 5'h02;
  localparam logic [4:0] RATIO_DIV5 = 5'h04;
  localparam logic [4:0] RATIO_DIV6 = 5'h05;
  localparam logic [4:0] RATIO_DIV8 = 5'h07;
  localparam logic [4:0] RATIO_DIV9 = 5'h08;
  localparam logic [4:0] RATIO_DIV11 = 5'h0A;
  localparam logic [4:0] RATIO_DIV12 = 5'h0B;
  localparam logic [4:0] RATIO_DIV17 = 5'h10;
  localparam logic [4:0] RATIO_DIV18 = 5'h11;

  // Reset values of the three divider ratio fields: the /1, /3, /6 set.
  localparam logic [4:0] RESET_RATIO_ONE = RATIO_DIV1;
  localparam logic [4:0] RESET_RATIO_TWO = RATIO_DIV3;
  localparam logic [4:0] RESET_RATIO_THREE = RATIO_DIV6;

  // Reset value of the module enable mask: every populated module running.
  localparam logic [40:0] RESET_ENABLE_MASK = 41'h1FF_FFFF_FFFF;

  // Populated module slots; unlisted indices are reserved.
  localparam logic [40:0] POPULATED_MASK = 41'h080_1F9F_FBFC;

  // Selected module index examples.
  localparam logic [5:0] IDX_TRANSFER_CHANNEL = 6'h02;
  localparam logic [5:0] IDX_MDIO = 6'h07;
  localparam logic [5:0] IDX_DDR2 = 6'h0D;
  localparam logic [5:0] IDX_UART0 = 6'h13;
  localparam logic [5:0] IDX_GPIO = 6'h1A;
  localparam logic [5:0] IDX_CORE = 6'h27;

  // Clock domain a module belongs to.
  typedef enum logic [1:0] {
    DOMAIN_FULL,
    DOMAIN_THIRD,
    DOMAIN_SIXTH,
    DOMAIN_REFERENCE
  } domain_t;

  // Domain of each module slot.
  function automatic domain_t domain_of(input logic [5:0] idx);
    domain_t d;
    d = DOMAIN_SIXTH;
    unique case (idx)
      6'h02, 6'h03, 6'h04, 6'h05, 6'h0D, 6'h0F: d = DOMAIN_THIRD;
      6'h12, 6'h13, 6'h14, 6'h17, 6'h18, 6'h19, 6'h1B, 6'h1C: d = DOMAIN_REFERENCE;
      6'h27: d = DOMAIN_FULL;
      default: d = DOMAIN_SIXTH;
    endcase
    return d;
  endfunction

endpackage

/* File: local_sleep_controller.sv */
// One local sleep controller: clock enable and module reset for a single module.
`timescale 1ns/1ps
module local_sleep_controller (
  input wire logic clock, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic populated, // High when this slot holds a real module.
  input wire logic enable_req, // Request to run the module clock.
  input wire logic reset_req, // Request to hold the module in reset.
  input wire logic domain_tick, // Enable pulse of the module's clock domain.
  output logic clock_enable, // Gated clock enable to the module.
  output logic module_reset_n, // Module reset, active low.
  output logic running // State: module clock running.
);

  typedef enum logic [1:0] {
    ST_RESET,
    ST_GATED,
    ST_ACTIVE
  } lsc_state_t;

  lsc_state_t state_q; // Current state.
  lsc_state_t state_d; // Next state.
  logic clock_enable_q; // Registered clock enable.
  logic clock_enable_d; // Next clock enable.
  logic reset_n_q; // Registered module reset.
  logic reset_n_d; // Next module reset.

  // Changes of state happen on a domain tick so the module sees whole domain cycles.
  always_comb begin
    state_d = state_q;
    if (!populated) begin
      state_d = ST_RESET; // Reserved slots stay parked.
    end else if (domain_tick) begin
      if (reset_req) begin
        state_d = ST_RESET;
      end else if (enable_req) begin
        state_d = ST_ACTIVE;
      end else begin
        state_d = ST_GATED;
      end
    end
    clock_enable_d = (state_d == ST_ACTIVE) && domain_tick;
    reset_n_d = (state_d != ST_RESET);
  end

  // Registers the state and the two controls.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_RESET;
      clock_enable_q <= 1'b0;
      reset_n_q <= 1'b0;
    end else begin
      state_q <= state_d;
      clock_enable_q <= clock_enable_d;
      reset_n_q <= reset_n_d;
    end
  end

  assign clock_enable = clock_enable_q;
  assign module_reset_n = reset_n_q;
  assign running = (state_q == ST_ACTIVE);

endmodule

/* File: clock_domain_gating_chk.sv */
// Concurrent checks on domain ticks, ratio loads and module gating.
`timescale 1ns/1ps
module clock_domain_gating_chk (
  input wire logic clock, // System clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic [clock_gating_pkg::RATIO_WIDTH-1:0] ratio_one, // First code.
  input wire logic [clock_gating_pkg::RATIO_WIDTH-1:0] ratio_two, // Second code.
  input wire logic [clock_gating_pkg::RATIO_WIDTH-1:0] ratio_three, // Third code.
  input wire logic ratio_load, // Load strobe.
  input wire logic full_rate_tick, // Full-rate tick.
  input wire logic third_rate_tick, // Third-rate tick.
  input wire logic sixth_rate_tick, // Sixth-rate tick.
  input wire logic reference_rate_tick, // Reference-rate tick.
  input wire logic [clock_gating_pkg::MODULE_COUNT-1:0] module_clock_enable, // Enables.
  input wire logic [clock_gating_pkg::MODULE_COUNT-1:0] module_reset_n, // Resets.
  input wire logic [clock_gating_pkg::MODULE_COUNT-1:0] module_running, // Running status.
  input wire logic ratio_error, // Refused load flag.
  input wire logic power_domain_on // Domain status.
);
  import clock_gating_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic legal_set; // High when the presented codes form an accepted set.
  logic [14:0] codes_q; // Codes in force.
  logic [5:0] gap_q [3]; // Cycles since the last tick of each domain.
  logic [2:0] seen_q; // A tick of each domain has been seen.
  assign legal_set = {ratio_one, ratio_two, ratio_three} inside {15'h0045, 15'h04AB, 15'h0911};
  // Tracks the codes in force and the spacing of ticks.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      codes_q <= 15'h0045;
      gap_q <= '{default: 6'h00};
      seen_q <= 3'h0;
    end else begin
      if (ratio_load && legal_set) begin
        codes_q <= {ratio_one, ratio_two, ratio_three};
      end
      gap_q[0] <= full_rate_tick ? 6'h01 : gap_q[0] + 6'h01;
      gap_q[1] <= third_rate_tick ? 6'h01 : gap_q[1] + 6'h01;
      gap_q[2] <= sixth_rate_tick ? 6'h01 : gap_q[2] + 6'h01;
      seen_q <= seen_q | {sixth_rate_tick, third_rate_tick, full_rate_tick};
    end
  end
  sequence all_ticks;
    full_rate_tick && third_rate_tick && sixth_rate_tick;
  endsequence
  property steady_period(logic tick, logic [5:0] gap, logic [4:0] code, logic seen);
    seen && !$past(ratio_load) |-> tick == (gap == {1'b0, code} + 6'h01);
  endproperty
  a_full_period: assert property (
    steady_period(full_rate_tick, gap_q[0], codes_q[14:10], seen_q[0]))
    else $error("full-rate tick spacing off");
  a_third_period: assert property (
    steady_period(third_rate_tick, gap_q[1], codes_q[9:5], seen_q[1]))
    else $error("third-rate tick spacing off");
  a_sixth_period: assert property (
    steady_period(sixth_rate_tick, gap_q[2], codes_q[4:0], seen_q[2]))
    else $error("sixth-rate tick spacing off");
  a_load_realign: assert property (ratio_load && legal_set |=> all_ticks)
    else $error("ticks not realigned after load");
  a_third_on_full: assert property (third_rate_tick |-> full_rate_tick)
    else $error("third-rate tick off a full-rate edge");
  a_sixth_on_third: assert property (sixth_rate_tick |-> third_rate_tick)
    else $error("sixth-rate tick off a third-rate edge");
  a_reference_rate: assert property ($past(rst_n) |-> reference_rate_tick)
    else $error("reference-rate tick missing");
  a_power_on: assert property (power_domain_on)
    else $error("power domain reported off");
  a_error_update: assert property (ratio_load |=> ratio_error == !$past(legal_set))
    else $error("ratio error flag wrong after load");
  a_error_hold: assert property (!ratio_load |=> $stable(ratio_error))
    else $error("ratio error flag moved without load");
  a_reserved_idle: assert property (((module_clock_enable | module_reset_n) & ~POPULATED_MASK) == '0)
    else $error("reserved slot active");
  a_ddr_domain: assert property (module_clock_enable[IDX_DDR2] |-> $past(third_rate_tick, 2))
    else $error("memory controller enable off its domain");
  a_gpio_domain: assert property (module_clock_enable[IDX_GPIO] |-> $past(sixth_rate_tick, 2))
    else $error("pin controller enable off its domain");
  // A reference-rate module ticks every cycle, so its enable must follow its running state.
  a_ref_gating: assert property (
    module_clock_enable[IDX_UART0] == module_running[IDX_UART0])
    else $error("reference-rate module enable differs from its state");
endmodule
bind clock_domain_gating clock_domain_gating_chk chk (.clock(clock), .rst_n(rst_n),
  .ratio_one(ratio_one), .ratio_two(ratio_two), .ratio_three(ratio_three),
  .ratio_load(ratio_load), .full_rate_tick(full_rate_tick), .third_rate_tick(third_rate_tick),
  .sixth_rate_tick(sixth_rate_tick), .reference_rate_tick(reference_rate_tick),
  .module_clock_enable(module_clock_enable), .module_reset_n(module_reset_n),
  .module_running(module_running),
  .ratio_error(ratio_error), .power_domain_on(power_domain_on));

/* File: clock_domain_gating_tb.sv */
// Self-checking testbench for the clock domain gating block.
`timescale 1ns/1ps
module clock_domain_gating_tb;
  import clock_gating_pkg::*;
  typedef struct {int at; int sel; logic [63:0] exp;} note_t;
  logic clock; // System clock.
  logic rst_n; // Reset, active low.
  logic [4:0] ratio_one, ratio_two, ratio_three, ra, rb, rc; // Codes.
  logic ratio_load, power_off_req; // Strobes.
  logic [40:0] enable_req, reset_req, module_clock_enable, module_reset_n, module_running;
  logic full_rate_tick, third_rate_tick, sixth_rate_tick, reference_rate_tick;
  logic ratio_error, power_domain_on; // Status.
  logic [5:0] tick_view; // Ticks and status packed for comparison.
  note_t q[$]; // Expected results, oldest first.
  int cyc = 0;
  int n_fail = 0;
  int tests_run = 0;
  int seed = 32'ha78f;
  // Module slots of the reference-rate domain, whose enables stay high while running.
  localparam logic [40:0] REF_SLOTS = 41'h0_1B9C_0000;
  assign tick_view = {full_rate_tick, third_rate_tick, sixth_rate_tick,
    reference_rate_tick, ratio_error, power_domain_on};
  clock_domain_gating dut (.clock(clock), .rst_n(rst_n), .ratio_one(ratio_one),
    .ratio_two(ratio_two), .ratio_three(ratio_three), .ratio_load(ratio_load),
    .enable_req(enable_req), .reset_req(reset_req), .power_off_req(power_off_req),
    .full_rate_tick(full_rate_tick), .third_rate_tick(third_rate_tick),
    .sixth_rate_tick(sixth_rate_tick), .reference_rate_tick(reference_rate_tick),
    .module_clock_enable(module_clock_enable), .module_reset_n(module_reset_n),
    .module_running(module_running), .ratio_error(ratio_error),
    .power_domain_on(power_domain_on));
  // Clock of 40 ns period.
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Cycle count, updated late so drivers read the old value.
  always @(posedge clock) cyc <= cyc + 1;
  task automatic check(input string name, input logic [63:0] exp, input logic [63:0] seen);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic note(input int at, input int sel, input logic [63:0] exp);
    q.push_back(note_t'{at, sel, exp});
  endtask
  // Takes each due note off the queue and compares it with the outputs.
  always @(negedge clock) begin
    while (q.size() > 0 && q[0].at <= cyc) begin
      case (q[0].sel)
        0: check("ticks", q[0].exp, {58'h0, tick_view});
        1: check("module_running", q[0].exp, {23'h0, module_running});
        2: check("module_reset_n", q[0].exp, {23'h0, module_reset_n});
        4: check("module_clock_enable", q[0].exp, {23'h0, module_clock_enable & REF_SLOTS});
        default: check("ratio_error", q[0].exp, {62'h0, tick_view[1:0]});
      endcase
      void'(q.pop_front());
    end
  end
  // Accepted sets are 0/2/5, 1/5/11 and 2/8/17.
  function automatic logic legal(input logic [4:0] a, input logic [4:0] b, input logic [4:0] c);
    return {a, b, c} inside {15'h0045, 15'h04AB, 15'h0911};
  endfunction
  // Loads one code set and notes the tick pattern or the refusal.
  task automatic load(input logic [4:0] a, input logic [4:0] b, input logic [4:0] c);
    @(posedge clock);
    ratio_one <= a;
    ratio_two <= b;
    ratio_three <= c;
    ratio_load <= 1'b1;
    power_off_req <= 1'($random(seed));
    if (legal(a, b, c)) begin
      for (int k = 0; k < 18; k++) begin
        note(cyc + 2 + k, 0, {58'h0, k % (a + 1) == 0, k % (b + 1) == 0,
          k % (c + 1) == 0, 3'b101});
      end
    end else begin
      note(cyc + 2, 3, 64'h3);
    end
    @(posedge clock);
    ratio_load <= 1'b0;
    repeat (18) @(posedge clock);
  endtask
  // Sets module requests and notes the settled state.
  task automatic modules(input logic [40:0] en, input logic [40:0] rst);
    @(posedge clock);
    enable_req <= en;
    reset_req <= rst;
    note(cyc + 40, 1, {23'h0, en & ~rst & POPULATED_MASK});
    note(cyc + 40, 2, {23'h0, ~rst & POPULATED_MASK});
    note(cyc + 40, 4, {23'h0, en & ~rst & POPULATED_MASK & REF_SLOTS});
    repeat (42) @(posedge clock);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    #(40 * 3000);
    n_fail++;
    close_out();
  end
  // Main sequence.
  initial begin
    {ratio_one, ratio_two, ratio_three, ratio_load, power_off_req} = '0;
    enable_req = '0;
    reset_req = '0;
    rst_n = 1'b0;
    note(1, 0, 64'h1);
    note(1, 2, 64'h0);
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    $display("test reset done");
    load(5'h01, 5'h05, 5'h0B);
    load(5'h02, 5'h08, 5'h10);
    load(5'h02, 5'h08, 5'h11);
    for (int i = 0; i < 3; i++) begin
      {ra, rb, rc} = 15'($random(seed));
      load(ra, rb, legal(ra, rb, rc) ? 5'h1F : rc);
    end
    load(5'h00, 5'h02, 5'h05);
    $display("test ratio sets done");
    modules({41{1'b1}}, 41'h0);
    modules({41{1'b1}}, 41'h0_0000_2000);
    for (int i = 0; i < 3; i++) begin
      modules(41'({$random(seed), $random(seed)}), 41'({$random(seed), $random(seed)}));
    end
    $display("test module gating done");
    close_out();
  end
endmodule
